//--- rtl/sfc_config_cmd.sv
// Functional notes
// - 01h with one byte loads status 1; two bytes load status 1 then 2.
// - 31h and 11h take exactly one byte for status 2 and status 3.
// - only the listed configuration bits change on a status write.
// - one-time lock bits once set to one by a timed status write never return to zero.
// - status write needs write-enable or volatile write-enable active.
// - suspend flags, write latch and cycle-active flag ignore status writes.
// - status write runs only if chip select rises after 8 or 16 data bits.
// - status write with write latch set starts a timed cycle; status reads stay possible.
// - cycle-active reads one during the cycle; write latch clears at its end.
// - hardware-protected mode refuses every status write.
// - C8h shifts extended address out, msb first, on falling clock edges.
// - extended address supplies bits 31..24 only in 3-byte mode.
// - C5h with one byte writes extended address only when write latch set.
// - extended address clears at power-up and on accepted software reset.
// - in 4-byte mode upper address bits of accesses overwrite extended address.
// - opcode-only B7h enters 4-byte address mode.
// - opcode-only E9h returns to 3-byte address mode.
// - reset needs 66h then 99h; anything else after 66h disarms it.
// - accepted reset aborts work and drops all volatile state.
// - after reset accepted, no instruction is taken for about 300us.
// - volatile write-enable never sets the write latch.
// - 05h, 35h, 15h return status bits 7..0, 15..8, 23..16.
`timescale 1ns/100ps
`default_nettype none
`include "sfc_defs.svh"
module sfc_config_cmd
  import sfc_pkg::*;
#(
  parameter int TW_CYCLES    = `SFC_TW_US * `SFC_MCLK_MHZ,
  parameter int RESET_CYCLES = `SFC_RESET_US * `SFC_MCLK_MHZ
) (
  // system
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // serial link
  input  wire logic        sclk,
  input  wire logic        csN,
  input  wire logic        si,
  output var  logic        so,
  output var  logic        soOe,
  input  wire logic        wpN,
  // memory access side
  input  wire logic        suspendA,
  input  wire logic        suspendB,
  input  wire logic        addrHighValid,
  input  wire logic [7:0]  addrHigh,
  // state out
  output var  logic [23:0] statusOut,
  output var  logic [7:0]  upperAddressByte,
  output var  logic [7:0]  accessAddrHigh,
  output var  logic        addressModeFlag,
  output var  logic        resetActive,
  output var  logic        clearReadModes
);

  // ---------------- link domain ----------------
  logic       fresh;
  logic [5:0] bitCnt;
  logic [6:0] shiftIn;
  logic [7:0] opcode;
  logic [7:0] data1;
  logic [7:0] data2;
  logic [7:0] shiftOut;
  logic       linkIdle;
  logic [5:0] next_bitCnt;
  logic       isRead;
  logic [7:0] readByte;
  logic       frameTog; // flips once per clocked frame, so a frame without clocks replays nothing
  // snapshot taken in the system domain, frozen for the frame
  logic [23:0] snapStatus;
  logic [7:0]  snapExt;
  logic        snapReady;
  assign linkIdle = csN | ~reset_n;
  assign next_bitCnt = fresh ? 6'd1 : (&bitCnt ? bitCnt : bitCnt + 6'd1);
  always_ff @(posedge sclk or posedge linkIdle) begin
    if (linkIdle) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      bitCnt  <= 6'd0;
      frameTog <= 1'b0;
      shiftIn <= 7'h00;
      opcode  <= 8'h00;
      data1   <= 8'h00;
      data2   <= 8'h00;
    end else begin
      bitCnt  <= next_bitCnt;
      frameTog <= frameTog ^ fresh;
      shiftIn <= {shiftIn[5:0], si};
      if (next_bitCnt == `SFC_BITS_OPCODE) begin
        opcode <= {shiftIn, si};
      end
      if (next_bitCnt == `SFC_BITS_ONE) begin
        data1 <= {shiftIn, si};
      end
      if (next_bitCnt == `SFC_BITS_TWO) begin
        data2 <= {shiftIn, si};
      end
    end
  end

  always_comb begin
    isRead   = snapReady;
    readByte = 8'h00;
    case (opcode)
      `SFC_OP_RD_SR1: readByte = snapStatus[7:0];
      `SFC_OP_RD_SR2: readByte = snapStatus[15:8];
      `SFC_OP_RD_SR3: readByte = snapStatus[23:16];
      `SFC_OP_RD_EXT: readByte = snapExt;
      default:        isRead = 1'b0;
    endcase
  end

  // byte repeats seven times in a continuous read, then zeros follow; data changes on falling edges
  always_ff @(negedge sclk or posedge linkIdle) begin
    if (linkIdle) begin
      so       <= 1'b0;
      soOe     <= 1'b0;
      shiftOut <= 8'h00;
    end else if (bitCnt >= `SFC_BITS_OPCODE && isRead) begin
      soOe <= 1'b1;
      if (bitCnt[2:0] == 3'd0) begin
        so       <= readByte[7];
        shiftOut <= {readByte[6:0], 1'b0};
      end else begin
        so       <= shiftOut[7];
        shiftOut <= {shiftOut[6:0], 1'b0};
      end
    end
  end

  // ---------------- system domain ----------------
  logic        csMeta;
  logic        csSync;
  logic        csPrev;
  logic        wpMeta;
  logic        wpSync;
  logic        csRise;
  logic        csFall;
  logic        seenTog;
  sfc_engine_t eng;
  logic [19:0] engCount;
  logic [23:0] statusVol;
  logic [23:0] statusNv;
  logic [23:0] pendStatus;
  logic        write_latch_flag;
  logic        volEn;
  logic        armed;
  logic [7:0]  extAddr;
  logic [23:0] readStatus;
  logic [2:0]  wrSel;
  logic [23:0] wrData;
  logic [23:0] wrMask;
  logic [23:0] next_status;
  logic        hwProt;
  logic        idle;
  logic        cmdValid;
  logic        opOnly;
  logic        wrOk;
  logic        extOk;
  logic        rstOk;
  // link words are read a few clocks after cs rise: host keeps cs high three clocks so they stay still
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      csMeta <= 1'b1;
      seenTog <= 1'b0;
      csSync <= 1'b1;
      csPrev <= 1'b1;
      wpMeta <= 1'b1;
      wpSync <= 1'b1;
    end else begin
      csMeta <= csN;
      csSync <= csMeta;
      csPrev <= csSync;
      wpMeta <= wpN;
      wpSync <= wpMeta;
      seenTog <= csRise ? frameTog : seenTog;
    end
  end
  assign csRise   = csSync & ~csPrev;
  assign csFall   = ~csSync & csPrev;
  assign idle     = (eng == ENG_IDLE);
  assign cmdValid = csRise && eng != ENG_RESET && bitCnt >= `SFC_BITS_OPCODE && frameTog != seenTog;
  assign opOnly   = (bitCnt == `SFC_BITS_OPCODE);
  assign hwProt   = statusVol[`SFC_BIT_STATUS_LOCK_BIT0] & ~statusVol[`SFC_BIT_STATUS_LOCK_BIT1] & ~wpSync;
  always_comb begin
    readStatus = statusVol & `SFC_WRITABLE;
    readStatus[`SFC_BIT_WIP]  = (eng == ENG_STATUS_WRITE);
    readStatus[`SFC_BIT_WEL]  = write_latch_flag;
    readStatus[`SFC_BIT_SUSPEND_FLAG_A] = suspendA;
    readStatus[`SFC_BIT_SUSPEND_FLAG_B] = suspendB;
  end
  always_comb begin
    wrSel  = 3'b000;
    wrData = 24'h000000;
    case (opcode)
      `SFC_OP_WR_SR1: begin
        if (bitCnt == `SFC_BITS_ONE) begin
          wrSel  = 3'b001;
          wrData = {16'h0000, data1};
        end else if (bitCnt == `SFC_BITS_TWO) begin
          wrSel  = 3'b011;
          wrData = {8'h00, data2, data1};
        end
      end
      `SFC_OP_WR_SR2: begin
        if (bitCnt == `SFC_BITS_ONE) begin
          wrSel  = 3'b010;
          wrData = {8'h00, data1, 8'h00};
        end
      end
      `SFC_OP_WR_SR3: begin
        if (bitCnt == `SFC_BITS_ONE) begin
          wrSel  = 3'b100;
          wrData = {data1, 16'h0000};
        end
      end
      default: ;
    endcase
    wrMask = {{8{wrSel[2]}}, {8{wrSel[1]}}, {8{wrSel[0]}}} & `SFC_WRITABLE;
    next_status = (statusVol & ~wrMask) | (wrData & wrMask);
    next_status[`SFC_BIT_LB_HI:`SFC_BIT_LB_LO] = next_status[`SFC_BIT_LB_HI:`SFC_BIT_LB_LO]
                                                | statusNv[`SFC_BIT_LB_HI:`SFC_BIT_LB_LO];
  end
  assign wrOk  = cmdValid && wrSel != 3'b000 && (write_latch_flag || volEn) && !hwProt && idle;
  assign extOk = cmdValid && opcode == `SFC_OP_WR_EXT && bitCnt == `SFC_BITS_ONE && write_latch_flag;
  assign rstOk = cmdValid && opOnly && opcode == `SFC_OP_RST && armed;

  // internal cycle engine
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      eng        <= ENG_IDLE;
      engCount   <= 20'h00000;
      pendStatus <= `SFC_STATUS_RST;
    end else if (rstOk) begin
      eng      <= ENG_RESET;
      engCount <= 20'(RESET_CYCLES - 1);
    end else begin
      unique case (eng)
        ENG_IDLE: begin
          if (wrOk && write_latch_flag) begin
            eng        <= ENG_STATUS_WRITE;
            engCount   <= 20'(TW_CYCLES - 1);
            pendStatus <= next_status;
          end
        end
        ENG_STATUS_WRITE, ENG_RESET: begin
          if (engCount == 20'h00000) begin
            eng <= ENG_IDLE;
          end else begin
            engCount <= engCount - 20'h00001;
          end
        end
      endcase
    end
  end

  // status contents
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      statusVol <= `SFC_STATUS_RST;
      statusNv  <= `SFC_STATUS_RST;
    end else if (rstOk) begin
      statusVol <= statusNv;
      statusVol[`SFC_BIT_ADS] <= statusNv[`SFC_BIT_ADP];
    end else if (eng == ENG_STATUS_WRITE && engCount == 20'h00000) begin
      statusVol <= pendStatus;
      statusNv  <= pendStatus;
    end else if (wrOk && !write_latch_flag) begin
      statusVol <= next_status;
    end else if (cmdValid && opOnly && opcode == `SFC_OP_ENTER4B) begin
      statusVol[`SFC_BIT_ADS] <= 1'b1;
    end else if (cmdValid && opOnly && opcode == `SFC_OP_EXIT4B) begin
      statusVol[`SFC_BIT_ADS] <= 1'b0;
    end
  end

  // write latch and volatile enable
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      write_latch_flag   <= 1'b0;
      volEn <= 1'b0;
    end else if (rstOk) begin
      write_latch_flag   <= 1'b0;
      volEn <= 1'b0;
    end else if (eng == ENG_STATUS_WRITE && engCount == 20'h00000) begin
      write_latch_flag <= cmdValid && opOnly && opcode == `SFC_OP_WREN && !volEn; // an enable in the same cycle wins
    end else if (wrOk && !write_latch_flag) begin
      volEn <= 1'b0;
    end else if (extOk) begin
      write_latch_flag <= 1'b0;
    end else if (cmdValid && opOnly) begin
      if (opcode == `SFC_OP_WREN && !volEn) begin
        write_latch_flag <= 1'b1;
      end
      if (opcode == `SFC_OP_WREN_VOL && !write_latch_flag) begin
        volEn <= 1'b1;
      end
      if (opcode == `SFC_OP_WRDI) begin
        write_latch_flag   <= 1'b0;
        volEn <= 1'b0;
      end
    end
  end

  // reset arming
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      armed <= 1'b0;
    end else if (cmdValid) begin
      armed <= opOnly && opcode == `SFC_OP_RST_EN;
    end
  end

  // extended address
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      extAddr <= `SFC_EXT_RST;
    end else if (rstOk) begin
      extAddr <= `SFC_EXT_RST;
    end else if (extOk) begin
      extAddr <= data1;
    end else if (statusVol[`SFC_BIT_ADS] && addrHighValid) begin
      extAddr <= addrHigh;
    end
  end

  // frozen copy for the link; a read frame sees status from its start
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      snapStatus <= `SFC_STATUS_RST;
      snapExt    <= `SFC_EXT_RST;
      snapReady  <= 1'b0;
    end else if (csFall) begin
      snapStatus <= readStatus;
      snapExt    <= extAddr;
      snapReady  <= (eng != ENG_RESET);
    end
  end

  // registered outputs
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      statusOut        <= `SFC_STATUS_RST;
      upperAddressByte <= `SFC_EXT_RST;
      accessAddrHigh   <= `SFC_EXT_RST;
      addressModeFlag  <= 1'b0;
      resetActive      <= 1'b0;
      clearReadModes   <= 1'b0;
    end else begin
      statusOut        <= readStatus;
      upperAddressByte <= extAddr;
      accessAddrHigh   <= statusVol[`SFC_BIT_ADS] ? 8'h00 : extAddr;
      addressModeFlag  <= statusVol[`SFC_BIT_ADS];
      resetActive      <= (eng == ENG_RESET);
      clearReadModes   <= rstOk;
    end
  end

endmodule // sfc_config_cmd
`default_nettype wire

//--- rtl/sfc_defs.svh
`ifndef SFC_DEFS_SVH
`define SFC_DEFS_SVH
// opcodes
`define SFC_OP_WREN      8'h06
`define SFC_OP_WREN_VOL  8'h50
`define SFC_OP_WRDI      8'h04
`define SFC_OP_RD_SR1    8'h05
`define SFC_OP_RD_SR2    8'h35
`define SFC_OP_RD_SR3    8'h15
`define SFC_OP_WR_SR1    8'h01
`define SFC_OP_WR_SR2    8'h31
`define SFC_OP_WR_SR3    8'h11
`define SFC_OP_RD_EXT    8'hC8
`define SFC_OP_WR_EXT    8'hC5
`define SFC_OP_ENTER4B   8'hB7
`define SFC_OP_EXIT4B    8'hE9
`define SFC_OP_RST_EN    8'h66
`define SFC_OP_RST       8'h99
// bit counts at chip-select rise, opcode included
`define SFC_BITS_OPCODE  6'd8
`define SFC_BITS_ONE     6'd16
`define SFC_BITS_TWO     6'd24
// status bit positions
`define SFC_BIT_WIP      0
`define SFC_BIT_WEL      1
`define SFC_BIT_STATUS_LOCK_BIT0     7
`define SFC_BIT_STATUS_LOCK_BIT1     8
`define SFC_BIT_SUSPEND_FLAG_B     10
`define SFC_BIT_LB_LO    11
`define SFC_BIT_LB_HI    13
`define SFC_BIT_SUSPEND_FLAG_A     15
`define SFC_BIT_ADS      16
`define SFC_BIT_ADP      17
// writable bits: SR1 FC, SR2 7B, SR3 E3
`define SFC_WRITABLE     24'hE37BFC
`define SFC_STATUS_RST   24'h000000
`define SFC_EXT_RST      8'h00
// timing
`define SFC_MCLK_MHZ     40
`define SFC_TW_US        5000
`define SFC_RESET_US     300
`endif

//--- rtl/sfc_pkg.sv
`default_nettype none
package sfc_pkg;
  typedef enum logic [1:0] {
    ENG_IDLE,
    ENG_STATUS_WRITE,
    ENG_RESET
  } sfc_engine_t;
endpackage
`default_nettype wire

//--- test/sfc_cfg_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module sfc_cfg_checker #(
  parameter int TW_CYCLES    = 20,
  parameter int RESET_CYCLES = 30
) (
  // system
  input wire logic        mclk,
  input wire logic        reset_n,
  // link
  input wire logic        csN,
  input wire logic        so,
  input wire logic        soOe,
  // state
  input wire logic        addrHighValid,
  input wire logic [7:0]  addrHigh,
  input wire logic [23:0] statusOut,
  input wire logic [7:0]  upperAddressByte,
  input wire logic [7:0]  accessAddrHigh,
  input wire logic        addressModeFlag,
  input wire logic        resetActive,
  input wire logic        clearReadModes
);
  logic [19:0] busyRun; // wide enough for a full-length write cycle
  logic [15:0] rstRun;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) busyRun <= 20'h00000;
    else busyRun <= statusOut[0] ? busyRun + 20'h00001 : 20'h00000;
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) rstRun <= 16'h0000;
    else rstRun <= resetActive ? rstRun + 16'h0001 : 16'h0000;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // csN is unsynchronised here, so allow it two samples to settle
  a_so_quiet: assert property (csN && $past(csN) && $past(csN, 2) |-> !soOe && !so)
    else $error("serial output driven while deselected");
  a_busy_span: assert property ($fell(statusOut[0]) && !resetActive |->
    busyRun >= TW_CYCLES - 1 && busyRun <= TW_CYCLES + 1) else $error("write cycle length off");
  a_latch_drop: assert property ($fell(statusOut[0]) |-> !statusOut[1])
    else $error("write latch kept after cycle");
  a_reset_span: assert property ($fell(resetActive) |->
    rstRun >= RESET_CYCLES - 1 && rstRun <= RESET_CYCLES + 1) else $error("reset interval length off");
  a_clear_pulse: assert property (clearReadModes |=> !clearReadModes)
    else $error("read mode clear longer than one cycle");
  a_reset_clears: assert property (clearReadModes |-> ##[0:2] resetActive && upperAddressByte == 8'h00)
    else $error("reset left extended address or skipped interval");
  a_ext_follow: assert property (addrHighValid && addressModeFlag && !resetActive |->
    ##2 upperAddressByte == $past(addrHigh, 2)) else $error("upper address not captured");
  a_addr_four: assert property (addressModeFlag && $past(addressModeFlag) && $past(addressModeFlag, 2) |->
    accessAddrHigh == 8'h00) else $error("extended address used in 4-byte mode");
  a_addr_three: assert property (!addressModeFlag && !$past(addressModeFlag) && !$past(addressModeFlag, 2) &&
    $stable(upperAddressByte) && $past(upperAddressByte, 2) == upperAddressByte |->
    accessAddrHigh == upperAddressByte) else $error("extended address not used in 3-byte mode");
  a_lock_keep: assert property (!resetActive |->
    (statusOut[13:11] & $past(statusOut[13:11])) == $past(statusOut[13:11])) else $error("lock bit cleared");
  c_busy: cover property ($fell(statusOut[0]));
  c_reset: cover property ($fell(resetActive));
  c_four: cover property ($rose(addressModeFlag));
endmodule // sfc_cfg_checker
bind sfc_config_cmd sfc_cfg_checker #(.TW_CYCLES(TW_CYCLES), .RESET_CYCLES(RESET_CYCLES)) i_chk (
  .mclk(mclk), .reset_n(reset_n), .csN(csN), .so(so), .soOe(soOe), .addrHighValid(addrHighValid),
  .addrHigh(addrHigh), .statusOut(statusOut), .upperAddressByte(upperAddressByte),
  .accessAddrHigh(accessAddrHigh), .addressModeFlag(addressModeFlag), .resetActive(resetActive),
  .clearReadModes(clearReadModes));
`default_nettype wire

//--- test/sfc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module sfc_host_model (
  // serial link
  output var  logic sclk,
  output var  logic csN,
  output var  logic si,
  input  wire logic so
);
  logic lclk;
  logic run;
  initial begin
    lclk = 1'h0;
    run = 1'h0;
    csN = 1'h1;
    si = 1'h0;
    #7;
    forever #24 lclk = ~lclk;
  end
  // run moves only while lclk is low: no slivers, and the clock rests between frames
  assign sclk = lclk & run;
  // nb bits of word, msb first; rd keeps the last eight bits seen on so
  task automatic frame(input logic [23:0] word, input int nb, output logic [7:0] rd);
    @(negedge lclk);
    csN <= 1'h0;
    repeat (2) @(negedge lclk);
    for (int i = 0; i < nb; i++) begin
      si <= word[23 - i];
      run <= 1'h1;
      @(posedge sclk);
      rd = {rd[6:0], so};
      @(negedge lclk);
    end
    run <= 1'h0;
    csN <= 1'h1;
    si <= ~si;
    repeat (3) @(negedge lclk);
  endtask
endmodule // sfc_host_model
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int TW  = 200;
  localparam int RST = 60;
  logic        mclk;
  logic        reset_n;
  logic        wpN;
  logic        suspendA;
  logic        suspendB;
  logic        ahv;
  logic [7:0]  ah;
  logic        sclk, csN, si, so, soOe;
  logic [23:0] st;
  logic [7:0]  ext, acc;
  logic        mode, rstAct, clr;
  int          badCount = 0;
  int          samplesChecked = 0;
  int          pulses = 0;
  sfc_config_cmd #(.TW_CYCLES(TW), .RESET_CYCLES(RST)) i_dut (
    .mclk(mclk), .reset_n(reset_n), .sclk(sclk), .csN(csN), .si(si), .so(so), .soOe(soOe),
    .wpN(wpN), .suspendA(suspendA), .suspendB(suspendB), .addrHighValid(ahv), .addrHigh(ah),
    .statusOut(st), .upperAddressByte(ext), .accessAddrHigh(acc), .addressModeFlag(mode),
    .resetActive(rstAct), .clearReadModes(clr));
  // an undriven output reads inverted, so a read without output enable cannot pass
  sfc_host_model i_host (.sclk(sclk), .csN(csN), .si(si), .so(soOe ? so : ~so));
  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (clr === 1'h1) pulses++;
  end
  task automatic completeRun;
    if (badCount == 0 && samplesChecked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input logic [23:0] w, input int nb);
    logic [7:0] r;
    i_host.frame(w, nb, r);
    repeat (6) @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] op, output logic [7:0] v);
    i_host.frame({op, 16'h0000}, 16, v);
    @(posedge mclk);
  endtask
  task automatic quiet;
    int n = 0;
    while ((st[0] | rstAct) !== 1'h0 && n < 400) begin
      @(posedge mclk);
      n++;
    end
    chk("quiet", 24'h000000, {23'h000000, st[0] | rstAct});
  endtask
  task automatic pulse(input logic [7:0] a);
    ahv <= 1'h1;
    ah <= a;
    @(posedge mclk);
    ahv <= 1'h0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic s_status;
    logic [7:0] v;
    suspendA <= 1'h1;
    suspendB <= 1'h1;
    rd(8'hC8, v);
    chk("ext boot", 24'h000000, {16'h0000, v});
    cmd(24'h060000, 8);
    cmd(24'h01FF38, 24);
    rd(8'h05, v);
    chk("busy read", 24'h000003, {16'h0000, v});
    quiet();
    chk("status", 24'h00BCFC, st);
    rd(8'h35, v);
    chk("sr2", 24'h0000BC, {16'h0000, v});
    rd(8'h05, v);
    chk("sr1", 24'h0000FC, {16'h0000, v});
    suspendA <= 1'h0;
    suspendB <= 1'h0;
    cmd(24'h060000, 8);
    cmd(24'h310000, 16);
    quiet();
    chk("lock", 24'h0038FC, st);
  endtask
  task automatic s_guard;
    logic [7:0] v;
    wpN <= 1'h0;
    cmd(24'h060000, 8);
    cmd(24'h010000, 16);
    chk("guarded", 24'h0038FE, st);
    wpN <= 1'h1;
    cmd(24'h010000, 16);
    quiet();
    chk("one byte", 24'h003800, st);
    cmd(24'h11FE00, 16);
    chk("no enable", 24'h003800, st);
    cmd(24'h500000, 8);
    chk("vol enable", 24'h003800, st);
    cmd(24'h11FE00, 16);
    chk("volatile", 24'hE23800, st);
    rd(8'h15, v);
    chk("sr3", 24'h0000E2, {16'h0000, v});
    cmd(24'h060000, 8);
    cmd(24'h01FF00, 12);
    cmd(24'h31FFFF, 24);
    chk("bad count", 24'hE23802, st);
    cmd(24'h040000, 8);
  endtask
  task automatic s_ext;
    logic [7:0] v;
    cmd(24'hC55A00, 16);
    chk("ext refused", 24'h000000, {16'h0000, ext});
    cmd(24'h060000, 8);
    cmd(24'hC55A00, 16);
    rd(8'hC8, v);
    chk("ext read", 24'h005A5A, {8'h00, v, acc});
    cmd(24'hB70000, 8);
    chk("four byte", 24'h000100, {15'h0000, mode, acc});
    pulse(8'hC3);
    chk("ext follow", 24'h0000C3, {16'h0000, ext});
    cmd(24'hE90000, 8);
    rd(8'hC8, v);
    pulse(8'h11);
    chk("three byte", 24'hC300C3, {v, 7'h00, mode, acc});
  endtask
  task automatic s_reset;
    logic [7:0] v;
    cmd(24'h660000, 8);
    cmd(24'h040000, 8);
    cmd(24'h990000, 8);
    chk("disarmed", 24'hC30000, {ext, 7'h00, rstAct, pulses[7:0]});
    rd(8'h05, v);
    chk("idle", 24'h000000, {16'h0000, v});
    cmd(24'h660000, 8);
    cmd(24'h990000, 8);
    chk("resetting", 24'h000001, {23'h000000, rstAct});
    cmd(24'h060000, 8);
    quiet();
    chk("reset state", 24'h003800, st);
    chk("reset ext", 24'h000001, {ext, 8'h00, pulses[7:0]});
  endtask
  initial begin
    reset_n = 1'h0;
    wpN = 1'h1;
    suspendA = 1'h0;
    suspendB = 1'h0;
    ahv = 1'h0;
    ah = 8'h00;
    repeat (16) @(posedge mclk);
    reset_n <= 1'h1;
    repeat (4) @(posedge mclk);
    s_status();
    s_guard();
    s_ext();
    s_reset();
    completeRun();
  end
  initial begin
    repeat (40000) @(posedge mclk);
    badCount++;
    completeRun();
  end
endmodule // tb
`default_nettype wire
